// ==== port0_device_end.sv ====
// Switch port 0 end of the MII/RMII link with its control registers.
// What this block does
// - MII MAC: sample PHY nibble, valid, error on its clock.
// - MII PHY: drive clock pin as timing reference.
// - MII MAC: nibble meaningful only with valid; error without valid is idle.
// - PHY modes: valid is TX_EN; RMII uses bits 1:0.
// - RMII MAC: valid is CRS_DV, data bits 1:0.
// - MII MAC: error means receive error or low power idle.
// - MII PHY: input error aborts current packet.
// - RMII MAC error flags receive error; RMII PHY ignores it.
// - PHY modes isolated: input pins ignored.
// - PHY modes isolated: data and clock drivers off.
// - Clock drive 16 mA only with strength and turbo both set, else 12 mA.
// - MII: drive four output bits toward far end.
// - RMII: only data bits 1:0; clock pin unused.
// - Role comes from straps on output data pins.
// - Straps caught after reset release, then held.
`timescale 1ns/1ps
`default_nettype none

module port0_device_end #(
  parameter logic [15:0] STRAP_MAP = port0_link_pkg::STRAP_MAP_DEFAULT
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  port0_link_if.device link,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic tx_valid_in,
  input wire logic [3:0] tx_data_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [3:0] rx_data_out,
  output logic rx_error_out,
  output logic rx_lpi_out,
  output logic rx_abort_out,
  output logic clk_drive_16ma_out
);
  localparam int SW = 11;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Every pin is sampled by two flops; only the second stage is read.
  logic [SW-1:0] sync1_ff, sync2_ff, pins;
  assign pins = {link.port0_in_data, link.port0_in_valid,
                 link.port0_in_error, link.port0_in_clock,
                 link.port0_out_data[3:1], link.ref_clock};

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
    end
  end

  logic [3:0] s_data;
  logic s_valid, s_error, s_clock, s_ref;
  logic [2:0] s_strap;
  assign {s_data, s_valid, s_error, s_clock, s_strap, s_ref} = sync2_ff;

  // ==========================================================================
  // State
  // ==========================================================================
  port0_link_pkg::port_mode_type mode_ff, nxt_mode;
  logic mode_ok_ff, nxt_mode_ok;
  logic [1:0] settle_ff, nxt_settle;
  logic [2:0] div_ff, nxt_div;
  logic clk_out_ff, nxt_clk_out;
  logic prev_clk_ff, nxt_prev_clk;
  logic iso_ff, nxt_iso, strength_ff, nxt_strength, turbo_ff, nxt_turbo;
  logic [2:0] sticky_ff, nxt_sticky;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [3:0] out_ff, nxt_out;
  logic out_valid_ff, nxt_out_valid;
  logic rx_valid_ff, nxt_rx_valid, rx_err_ff, nxt_rx_err;
  logic rx_lpi_ff, nxt_rx_lpi, rx_abort_ff, nxt_rx_abort;
  logic [3:0] rx_data_ff, nxt_rx_data;

  logic is_mii, is_phy, isolated, link_clk, rise, live;
  logic fifo_valid, fifo_ready;
  logic [3:0] fifo_data;
  logic [3:0] in_data_g;
  logic in_valid_g, in_error_g;
  logic [2:0] ev;

  assign is_mii = (mode_ff == port0_link_pkg::MODE_MII_MAC) ||
                  (mode_ff == port0_link_pkg::MODE_MII_PHY);
  assign is_phy = (mode_ff == port0_link_pkg::MODE_MII_PHY) ||
                  (mode_ff == port0_link_pkg::MODE_RMII_PHY);
  assign isolated = is_phy & iso_ff;
  // In RMII the clock pin is unused, so the shared reference clock times
  // the lanes instead.
  assign link_clk = is_mii ? s_clock : s_ref;
  assign rise = link_clk & ~prev_clk_ff;
  assign live = mode_ok_ff & ~isolated;
  // Isolated inputs read as if the pin were switched off.
  assign in_data_g = isolated ? 4'h0 : s_data;
  assign in_valid_g = s_valid & ~isolated;
  assign in_error_g = s_error & ~isolated;

  // ==========================================================================
  // Transmit buffer
  // ==========================================================================
  // The FIFO drains only on link edges, so a slow link stalls the writer.
  assign fifo_ready = rise & live;

  port0_nibble_fifo #(
    .WIDTH(port0_link_pkg::NIBBLE_W),
    .DEPTH(port0_link_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .wr_valid_in(tx_valid_in),
    .wr_data_in(tx_data_in),
    .wr_ready_out(tx_ready_out),
    .rd_valid_out(fifo_valid),
    .rd_data_out(fifo_data),
    .rd_ready_in(fifo_ready)
  );

  // ==========================================================================
  // Straps, divider, link edges
  // ==========================================================================
  // Straps are read a fixed number of cycles after release so the
  // synchronisers hold true pin levels, not their reset value.
  always_comb begin
    nxt_settle = settle_ff;
    nxt_mode = mode_ff;
    nxt_mode_ok = mode_ok_ff;
    if (!mode_ok_ff) begin
      if (settle_ff == port0_link_pkg::STRAP_SETTLE) begin
        nxt_mode = port0_link_pkg::port_mode_type'(
                     STRAP_MAP[{s_strap, 1'b0} +: 2]);
        nxt_mode_ok = 1'b1;
      end else begin
        nxt_settle = settle_ff + 2'h1;
      end
    end
    nxt_div = (div_ff == port0_link_pkg::DIV_LAST) ? 3'h0 : div_ff + 3'h1;
    nxt_clk_out = (nxt_div < port0_link_pkg::DIV_HALF);
    nxt_prev_clk = link_clk;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      settle_ff <= 2'h0;
      mode_ff <= port0_link_pkg::MODE_MII_MAC;
      mode_ok_ff <= 1'b0;
      div_ff <= 3'h0;
      clk_out_ff <= 1'b0;
      prev_clk_ff <= 1'b0;
    end else begin
      settle_ff <= nxt_settle;
      mode_ff <= nxt_mode;
      mode_ok_ff <= nxt_mode_ok;
      div_ff <= nxt_div;
      clk_out_ff <= nxt_clk_out;
      prev_clk_ff <= nxt_prev_clk;
    end
  end

  // ==========================================================================
  // Receive and transmit on link rising edges
  // ==========================================================================
  // Events: bit 0 receive error, bit 1 low power idle, bit 2 abort.
  always_comb begin
    ev = 3'h0;
    nxt_rx_valid = 1'b0;
    nxt_rx_data = rx_data_ff;
    nxt_out = out_ff;
    nxt_out_valid = out_valid_ff;
    if (rise && live) begin
      nxt_rx_valid = in_valid_g;
      if (in_valid_g) begin
        nxt_rx_data = is_mii ? in_data_g
                             : {2'h0, in_data_g[1:0]};
      end
      unique case (mode_ff)
        port0_link_pkg::MODE_MII_MAC: begin
          ev[0] = in_error_g & in_valid_g;
          ev[1] = in_error_g & ~in_valid_g;
        end
        port0_link_pkg::MODE_MII_PHY: begin
          ev[2] = in_error_g & in_valid_g;
        end
        port0_link_pkg::MODE_RMII_MAC: begin
          ev[0] = in_error_g & in_valid_g;
        end
        port0_link_pkg::MODE_RMII_PHY: begin
          ev = 3'h0;
        end
      endcase
      nxt_out_valid = fifo_valid;
      nxt_out = fifo_valid ? fifo_data : 4'h0;
    end
    if (!live) begin
      nxt_out_valid = 1'b0;
    end
    nxt_rx_err = ev[0];
    nxt_rx_lpi = ev[1];
    nxt_rx_abort = ev[2];
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_valid_ff <= 1'b0;
      rx_data_ff <= 4'h0;
      rx_err_ff <= 1'b0;
      rx_lpi_ff <= 1'b0;
      rx_abort_ff <= 1'b0;
      out_ff <= 4'h0;
      out_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= nxt_rx_valid;
      rx_data_ff <= nxt_rx_data;
      rx_err_ff <= nxt_rx_err;
      rx_lpi_ff <= nxt_rx_lpi;
      rx_abort_ff <= nxt_rx_abort;
      out_ff <= nxt_out;
      out_valid_ff <= nxt_out_valid;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Sticky flags clear on writing one; a new event in that cycle wins.
  always_comb begin
    nxt_iso = iso_ff;
    nxt_strength = strength_ff;
    nxt_turbo = turbo_ff;
    nxt_sticky = sticky_ff;
    nxt_rdata = 16'h0000;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        port0_link_pkg::REG_BASIC_CTRL: begin
          nxt_iso = reg_wdata_in[port0_link_pkg::BASIC_ISOLATE_POS];
        end
        port0_link_pkg::REG_SPECIAL_CTRL: begin
          nxt_strength = reg_wdata_in[port0_link_pkg::SPECIAL_CLK_STRENGTH_POS];
          nxt_turbo = reg_wdata_in[port0_link_pkg::SPECIAL_TURBO_POS];
        end
        port0_link_pkg::REG_STATUS: begin
          nxt_sticky = sticky_ff & ~reg_wdata_in[2:0];
        end
        default: begin
          nxt_sticky = sticky_ff;
        end
      endcase
    end
    nxt_sticky = nxt_sticky | {rx_abort_ff, rx_lpi_ff, rx_err_ff};
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        port0_link_pkg::REG_BASIC_CTRL: begin
          nxt_rdata[port0_link_pkg::BASIC_ISOLATE_POS] = iso_ff;
        end
        port0_link_pkg::REG_SPECIAL_CTRL: begin
          nxt_rdata[port0_link_pkg::SPECIAL_CLK_STRENGTH_POS] = strength_ff;
          nxt_rdata[port0_link_pkg::SPECIAL_TURBO_POS] = turbo_ff;
          nxt_rdata[port0_link_pkg::SPECIAL_MODE_POS +: 2] = mode_ff;
          nxt_rdata[port0_link_pkg::SPECIAL_MODE_OK_POS] = mode_ok_ff;
        end
        port0_link_pkg::REG_STATUS: begin
          nxt_rdata[2:0] = sticky_ff;
        end
        default: begin
          nxt_rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      iso_ff <= port0_link_pkg::RESET_ISOLATE;
      strength_ff <= port0_link_pkg::RESET_CLK_STRENGTH;
      turbo_ff <= port0_link_pkg::RESET_TURBO;
      sticky_ff <= 3'h0;
      rdata_ff <= 16'h0000;
    end else begin
      iso_ff <= nxt_iso;
      strength_ff <= nxt_strength;
      turbo_ff <= nxt_turbo;
      sticky_ff <= nxt_sticky;
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Data drivers stay off until the straps are caught, so the strap
  // resistors alone set the pin levels during that window.
  assign link.out_dev_o = out_ff;
  assign link.out_dev_oe = !live ? 4'h0 :
                           is_mii ? 4'hF :
                           {2'h0, port0_link_pkg::RMII_LANES};
  // Valid drops with the drivers, not a cycle after them.
  assign link.port0_out_valid = out_valid_ff & live;
  assign link.clk_dev_o = clk_out_ff;
  assign link.clk_dev_oe = live &&
                           (mode_ff == port0_link_pkg::MODE_MII_PHY);
  assign clk_drive_16ma_out = strength_ff & turbo_ff &
                              link.clk_dev_oe;
  assign reg_rdata_out = rdata_ff;
  assign rx_valid_out = rx_valid_ff;
  assign rx_data_out = rx_data_ff;
  assign rx_error_out = rx_err_ff;
  assign rx_lpi_out = rx_lpi_ff;
  assign rx_abort_out = rx_abort_ff;
endmodule : port0_device_end

`default_nettype wire

// ==== port0_link_if.sv ====
// Pin bundle between the switch port 0 end and the far-end PHY or MAC.
`timescale 1ns/1ps
`default_nettype none

interface port0_link_if;
  logic [3:0] port0_in_data;
  logic port0_in_valid;
  logic port0_in_error;
  logic clk_dev_o;
  logic clk_dev_oe;
  logic clk_par_o;
  logic clk_par_oe;
  logic port0_in_clock;
  logic [3:0] out_dev_o;
  logic [3:0] out_dev_oe;
  logic [3:1] strap_level;
  logic [3:0] port0_out_data;
  logic port0_out_valid;
  logic ref_clock;

  // ==========================================================================
  // Wire resolution
  // ==========================================================================
  // The clock pin is pulled down when nobody drives it.
  assign port0_in_clock = clk_dev_oe ? clk_dev_o : (clk_par_oe & clk_par_o);
  // Undriven data bits 3..1 show the strap resistors, bit 0 reads low.
  assign port0_out_data[0] = out_dev_oe[0] & out_dev_o[0];
  assign port0_out_data[3:1] = (out_dev_oe[3:1] & out_dev_o[3:1]) |
                               (~out_dev_oe[3:1] & strap_level);

  modport device (
    input port0_in_data, port0_in_valid, port0_in_error, port0_in_clock,
    input port0_out_data, ref_clock,
    output clk_dev_o, clk_dev_oe, out_dev_o, out_dev_oe, port0_out_valid
  );
  modport partner (
    output port0_in_data, port0_in_valid, port0_in_error,
    output clk_par_o, clk_par_oe, strap_level, ref_clock,
    input port0_in_clock, port0_out_data, port0_out_valid
  );
endinterface : port0_link_if

`default_nettype wire

// ==== port0_link_monitor.sv ====
// Pin-level checker for the port 0 link between the two ends.
`timescale 1ns/1ps
`default_nettype none

module port0_link_monitor (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_dev_o,
  input wire logic clk_dev_oe,
  input wire logic clk_par_oe,
  input wire logic [3:0] out_dev_oe,
  input wire logic [3:1] strap_level,
  input wire logic port0_out_valid,
  input wire logic port0_in_error
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic [1:0] mode_ff;
  logic [2:0] up_ff;
  logic [2:0] nxt_up;

  // ==========================================================================
  // Role and settle tracking
  // ==========================================================================
  // Saturates so late checks stay armed for the rest of the run.
  always_comb begin
    nxt_up = (up_ff == 3'h7) ? up_ff : up_ff + 3'h1;
  end
  // Straps are captured while reset keeps the drivers off.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mode_ff <= strap_level[2:1];
      up_ff <= 3'h0;
    end else begin
      up_ff <= nxt_up;
    end
  end

  sequence clk_high3; clk_dev_o [*3]; endsequence
  sequence clk_low4; !clk_dev_o [*4]; endsequence

  no_dual_drive_a: assert property (!(clk_dev_oe && clk_par_oe))
    else $error("both ends drive the clock pin");
  clk_owner_a: assert property (mode_ff != 2'h1 |-> !clk_dev_oe)
    else $error("device clock driven outside MII PHY role");
  phy_clk_shape_a: assert property ($rose(clk_dev_o) && clk_dev_oe
    |=> clk_high3 ##1 clk_low4 ##1 clk_dev_o)
    else $error("device clock period wrong");
  mac_clk_in_a: assert property (mode_ff == 2'h0 && up_ff == 3'h7
    |-> clk_par_oe) else $error("far clock missing in MII MAC role");
  rmii_clk_pin_a: assert property (mode_ff[1] |-> !clk_par_oe)
    else $error("clock pin driven in RMII role");
  rmii_upper_a: assert property (mode_ff[1]
    |-> out_dev_oe[3:2] == 2'h0)
    else $error("upper data driven in RMII role");
  strap_quiet_a: assert property (up_ff < 3'h3 |-> out_dev_oe == 4'h0)
    else $error("data driven before straps are caught");
  valid_drive_a: assert property (port0_out_valid |-> out_dev_oe[0])
    else $error("valid without data drivers");
  rmii_no_err_a: assert property (mode_ff == 2'h3 |-> !port0_in_error)
    else $error("error pin raised in RMII PHY role");
endmodule : port0_link_monitor

`default_nettype wire

// ==== port0_link_pkg.sv ====
// Shared constants and types for the switch port 0 MII/RMII link.
package port0_link_pkg;

  // ==========================================================================
  // Port roles
  // ==========================================================================
  typedef enum logic [1:0] {
    MODE_MII_MAC  = 2'h0,
    MODE_MII_PHY  = 2'h1,
    MODE_RMII_MAC = 2'h2,
    MODE_RMII_PHY = 2'h3
  } port_mode_type;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int SYS_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam int LINK_DIV = LINK_PERIOD_NS / SYS_PERIOD_NS;
  localparam logic [2:0] DIV_LAST = 3'(LINK_DIV - 1);
  localparam logic [2:0] DIV_HALF = 3'(LINK_DIV / 2);
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // Strap value (3 bits) to role, two bits per entry, entry 0 lowest.
  localparam logic [15:0] STRAP_MAP_DEFAULT = 16'hE4E4;

  // ==========================================================================
  // Data path
  // ==========================================================================
  localparam int NIBBLE_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam logic [1:0] RMII_LANES = 2'h3;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int REG_AW = 4;
  localparam int REG_DW = 16;
  localparam logic [3:0] REG_BASIC_CTRL = 4'h0;
  localparam logic [3:0] REG_SPECIAL_CTRL = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam int BASIC_ISOLATE_POS = 10;
  localparam int SPECIAL_CLK_STRENGTH_POS = 0;
  localparam int SPECIAL_TURBO_POS = 1;
  localparam int SPECIAL_MODE_POS = 4;
  localparam int SPECIAL_MODE_OK_POS = 6;
  localparam int STATUS_RX_ERR_POS = 0;
  localparam int STATUS_LPI_POS = 1;
  localparam int STATUS_ABORT_POS = 2;
  localparam logic RESET_ISOLATE = 1'b0;
  localparam logic RESET_CLK_STRENGTH = 1'b0;
  localparam logic RESET_TURBO = 1'b0;

endpackage : port0_link_pkg

// ==== port0_nibble_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module port0_nibble_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic wr_valid_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic wr_ready_out,
  output logic rd_valid_out,
  output logic [WIDTH-1:0] rd_data_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  logic [AW:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic push, pop;

  // Full when pointers differ only in the wrap bit.
  assign wr_ready_out = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                          (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
  assign rd_valid_out = (wr_ptr_ff != rd_ptr_ff);
  assign rd_data_out = mem_ff[rd_ptr_ff[AW-1:0]];
  assign push = wr_valid_in & wr_ready_out;
  assign pop = rd_ready_in & rd_valid_out;

  // Pointer and storage updates.
  always_comb begin
    nxt_mem = mem_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    if (push) begin
      nxt_mem[wr_ptr_ff[AW-1:0]] = wr_data_in;
      nxt_wr_ptr = wr_ptr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd_ptr = rd_ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      mem_ff <= nxt_mem;
    end
  end
endmodule : port0_nibble_fifo

`default_nettype wire

// ==== port0_partner_end.sv ====
// Far end of the port 0 link: an external PHY or MAC built as logic.
`timescale 1ns/1ps
`default_nettype none

module port0_partner_end (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  port0_link_if.partner link,
  input wire logic [1:0] role_in,
  input wire logic [2:0] strap_in,
  input wire logic tx_valid_in,
  input wire logic [3:0] tx_data_in,
  input wire logic tx_error_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [3:0] rx_data_out
);
  // ==========================================================================
  // Synchronisers and edges
  // ==========================================================================
  logic [5:0] sync1_ff, sync2_ff;
  logic [2:0] div_ff, nxt_div;
  logic clk_ff, nxt_clk, prev_ff, nxt_prev;
  logic [3:0] d_ff, nxt_d, rx_d_ff, nxt_rx_d;
  logic v_ff, nxt_v, e_ff, nxt_e, rx_v_ff, nxt_rx_v;
  logic is_mii, is_rmii_phy, s_clk, s_valid, rise;
  logic [3:0] s_data;

  assign is_mii = (role_in == port0_link_pkg::MODE_MII_MAC) ||
                  (role_in == port0_link_pkg::MODE_MII_PHY);
  assign is_rmii_phy = (role_in == port0_link_pkg::MODE_RMII_PHY);
  assign {s_data, s_valid} = sync2_ff[5:1];
  assign s_clk = is_mii ? sync2_ff[0] : clk_ff;
  assign rise = s_clk & ~prev_ff;
  assign tx_ready_out = rise;

  // Drive one unit per link rise; the device reads it one period later.
  always_comb begin
    nxt_div = (div_ff == port0_link_pkg::DIV_LAST) ? 3'h0 : div_ff + 3'h1;
    nxt_clk = (nxt_div < port0_link_pkg::DIV_HALF);
    nxt_prev = s_clk;
    nxt_d = d_ff;
    nxt_v = v_ff;
    nxt_e = e_ff;
    nxt_rx_v = 1'b0;
    nxt_rx_d = rx_d_ff;
    if (rise) begin
      nxt_v = tx_valid_in;
      nxt_d = !tx_valid_in ? 4'h0 : is_mii ? tx_data_in
                                           : {2'h0, tx_data_in[1:0]};
      nxt_e = tx_error_in & ~is_rmii_phy;
      nxt_rx_v = s_valid;
      if (s_valid) begin
        nxt_rx_d = is_mii ? s_data : {2'h0, s_data[1:0]};
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      div_ff <= 3'h0;
      clk_ff <= 1'b0;
      prev_ff <= 1'b0;
      d_ff <= 4'h0;
      v_ff <= 1'b0;
      e_ff <= 1'b0;
      rx_v_ff <= 1'b0;
      rx_d_ff <= 4'h0;
    end else begin
      sync1_ff <= {link.port0_out_data, link.port0_out_valid,
                   link.port0_in_clock};
      sync2_ff <= sync1_ff;
      div_ff <= nxt_div;
      clk_ff <= nxt_clk;
      prev_ff <= nxt_prev;
      d_ff <= nxt_d;
      v_ff <= nxt_v;
      e_ff <= nxt_e;
      rx_v_ff <= nxt_rx_v;
      rx_d_ff <= nxt_rx_d;
    end
  end

  // ==========================================================================
  // Pins
  // ==========================================================================
  // Acting as PHY in MII, this end owns the clock pin.
  assign link.clk_par_o = clk_ff;
  assign link.clk_par_oe = (role_in == port0_link_pkg::MODE_MII_MAC);
  assign link.ref_clock = clk_ff;
  assign link.strap_level = strap_in;
  assign link.port0_in_data = d_ff;
  assign link.port0_in_valid = v_ff;
  assign link.port0_in_error = e_ff;
  assign rx_valid_out = rx_v_ff;
  assign rx_data_out = rx_d_ff;
endmodule : port0_partner_end

`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the port 0 link in every strap role.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  miscompares++; $display("ERROR %s exp %0h got %0h", n, e, s); end end

module tb_top;
  logic sys_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic dtx_v = 1'h0;
  logic ptx_v = 1'h0;
  logic ptx_e = 1'h0;
  logic [3:0] dtx_d = 4'h0;
  logic [3:0] ptx_d = 4'h0;
  logic [1:0] role = 2'h0;
  logic seen_full = 1'h0;
  logic dtx_rdy, ptx_rdy, drx_v, prx_v, drv16;
  logic [3:0] drx_d, prx_d, msk, x;
  logic [15:0] reg_rdata, rdata;
  logic [3:0] got_p[$], got_d[$], exp_p[$], exp_d[$];
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;

  // ==========================================================================
  // Two ends joined by the link
  // ==========================================================================
  port0_link_if link ();
  port0_device_end i_port0_device_end (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .link(link), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .tx_valid_in(dtx_v), .tx_data_in(dtx_d),
    .tx_ready_out(dtx_rdy), .rx_valid_out(drx_v), .rx_data_out(drx_d),
    .rx_error_out(), .rx_lpi_out(), .rx_abort_out(),
    .clk_drive_16ma_out(drv16));
  port0_partner_end i_port0_partner_end (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .link(link), .role_in(role), .strap_in({1'h0, role}),
    .tx_valid_in(ptx_v), .tx_data_in(ptx_d), .tx_error_in(ptx_e),
    .tx_ready_out(ptx_rdy), .rx_valid_out(prx_v), .rx_data_out(prx_d));
  port0_link_monitor i_port0_link_monitor (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .clk_dev_o(link.clk_dev_o), .clk_dev_oe(link.clk_dev_oe),
    .clk_par_oe(link.clk_par_oe), .out_dev_oe(link.out_dev_oe),
    .strap_level(link.strap_level), .port0_out_valid(link.port0_out_valid),
    .port0_in_error(link.port0_in_error));

  // The 25 MHz system clock.
  initial forever #20 sys_clk_in = ~sys_clk_in;

  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  // Read data is taken mid-cycle, where it stands for its single cycle.
  task reg_op(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge sys_clk_in);
    {reg_wr, reg_rd} <= 2'h0;
    @(negedge sys_clk_in);
    rdata = reg_rdata;
  endtask : reg_op

  // Holds one unit on either end until that end's ready is seen.
  task send(input logic p, input logic v, input logic [3:0] d,
            input logic e);
    @(posedge sys_clk_in);
    if (p) {ptx_v, ptx_d, ptx_e} <= {v, d, e};
    else {dtx_v, dtx_d} <= {1'h1, d};
    @(negedge sys_clk_in);
    while ((p ? ptx_rdy : dtx_rdy) !== 1'h1) @(negedge sys_clk_in);
    @(posedge sys_clk_in);
    {ptx_v, dtx_v, ptx_e} <= 3'h0;
  endtask : send

  function automatic logic [15:0] exp_stat(input int r);
    return (r == 0) ? 16'h3 : (r == 1) ? 16'h4 : (r == 3) ? 16'h0 : 16'h1;
  endfunction : exp_stat

  // Outputs are sampled mid-cycle so pulses are settled; also the hang guard.
  always @(negedge sys_clk_in) begin
    cycles++;
    if (prx_v === 1'h1) got_p.push_back(prx_d);
    if (drx_v === 1'h1) got_d.push_back(drx_d);
    if (!rst_in && dtx_rdy === 1'h0) seen_full = 1'h1;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  // Each role needs its own reset, since straps are caught only then.
  initial begin
    void'($urandom(32'hD073));
    for (int r = 0; r < 4; r++) begin
      role <= 2'(r);
      rst_in <= 1'h1;
      repeat (20) @(posedge sys_clk_in);
      rst_in <= 1'h0;
      msk = r[1] ? 4'h3 : 4'hF;
      repeat (4) @(posedge sys_clk_in);
      reg_op(1'h0, 4'h1, 16'h0);
      `CHK("role", {9'h0, 1'h1, 2'(r), 4'h0}, rdata)
      reg_op(1'h0, 4'hF, 16'h0);
      `CHK("unmapped", 16'h0, rdata)
      got_p.delete();
      got_d.delete();
      exp_p.delete();
      exp_d.delete();
      seen_full = 1'h0;
      for (int i = 0; i < 24; i++) begin
        x = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($urandom);
        exp_p.push_back(x & msk);
        send(1'h0, 1'h1, x, 1'h0);
      end
      // The last unit raises error with valid low: idle signalling in MII MAC.
      for (int i = 0; i < 9; i++) begin
        x = 4'($urandom);
        if (i < 8) exp_d.push_back(x & msk);
        send(1'h1, i < 8, x, i >= 7);
      end
      repeat (300) @(posedge sys_clk_in);
      `CHK("full", 1'h1, seen_full)
      `CHK("far count", 24, got_p.size())
      foreach (exp_p[i]) `CHK("far data", exp_p[i], got_p[i] & msk)
      `CHK("near count", 8, got_d.size())
      for (int i = 0; i < 8; i++)
        `CHK("near data", exp_d[i], got_d[i] & msk)
      reg_op(1'h0, 4'h2, 16'h0);
      `CHK("status", exp_stat(r), rdata)
      reg_op(1'h1, 4'h2, 16'h7);
      reg_op(1'h0, 4'h2, 16'h0);
      `CHK("cleared", 16'h0, rdata)
      if (r == 1) begin
        reg_op(1'h1, 4'h1, 16'h2);
        `CHK("drive", 1'h0, drv16)
        reg_op(1'h1, 4'h1, 16'h3);
        `CHK("drive", 1'h1, drv16)
      end
      if (r[0]) begin
        reg_op(1'h1, 4'h0, 16'h400);
        repeat (3) @(negedge sys_clk_in);
        `CHK("isolate", 5'h0, {link.clk_dev_oe, link.out_dev_oe})
        if (r[1]) begin
          send(1'h1, 1'h1, 4'h3, 1'h0);
          repeat (20) @(posedge sys_clk_in);
          `CHK("isolated rx", 8, got_d.size())
        end
      end
    end
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
